// ---- verilog/fpm_pkg.sv ----
// package: widths, control codes and register map of the fixed-point sequencer
package fpm_pkg;
  localparam int WORD_W = 40;
  localparam int MAG_W = 39;
  localparam int INT_W = 16;
  localparam int FRAC_W = 23;
  localparam int SIGN_BIT = 39;
  localparam logic [38:0] MAG_MAX = 39'h7F_FFFF_FFFF;
  localparam int CODE_W = 8;
  localparam int STEP_W = 10;
  localparam int SEG_W = 6;
  localparam logic [9:0] STEP_MAX_DEF = 10'h3FF;
  localparam int NREG = 8;
  localparam int DAC_W = 17;
  // single-function codes
  localparam logic [7:0] C_NOP = 8'h00;
  localparam logic [7:0] C_ADD = 8'h01;
  localparam logic [7:0] C_SUB = 8'h02;
  localparam logic [7:0] C_NEG = 8'h03;
  localparam logic [7:0] C_MUL = 8'h04;
  localparam logic [7:0] C_DIV = 8'h05;
  localparam logic [7:0] C_SQRT = 8'h06;
  localparam logic [7:0] C_SHR = 8'h07;
  localparam logic [7:0] C_SHL = 8'h08;
  localparam logic [7:0] C_ABS = 8'h09;
  localparam logic [7:0] C_MAX = 8'h0A;
  localparam logic [7:0] C_MIN = 8'h0B;
  localparam logic [7:0] C_WMASK = 8'h0C;
  localparam logic [7:0] C_GT = 8'h0D;
  localparam logic [7:0] C_EQ = 8'h0E;
  localparam logic [7:0] C_LT = 8'h0F;
  localparam logic [7:0] C_LE = 8'h10;
  localparam logic [7:0] C_GE = 8'h11;
  localparam logic [7:0] C_HYST = 8'h12;
  localparam logic [7:0] C_WIN = 8'h13;
  // indexed groups: upper five bits pick the group, lower three the index
  localparam logic [4:0] G_STORE = 5'h08;
  localparam logic [4:0] G_SELA = 5'h09;
  localparam logic [4:0] G_SELB = 5'h0A;
  localparam logic [4:0] G_SELC = 5'h0B;
  localparam logic [4:0] G_ADCGO = 5'h0C;
  localparam logic [4:0] G_ADCLD = 5'h0D;
  localparam logic [4:0] G_PULSE = 5'h0E;
  localparam logic [4:0] G_TSTORE = 5'h0F;
  localparam logic [4:0] G_DAC = 5'h10;
  localparam logic [4:0] G_RAMWR = 5'h11;
  localparam logic [4:0] G_RAMRD = 5'h12;
  localparam logic [4:0] G_RAMADR = 5'h13;
  // axi register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_STEP = 8'h08;
  localparam logic [7:0] A_RES_LO = 8'h0C;
  localparam logic [7:0] A_RES_HI = 8'h10;
  localparam logic [7:0] A_TRIP = 8'h14;
  localparam logic [7:0] A_CODE = 8'h18;
  // control bits and status bits
  localparam int CTRL_DAC_SYS = 0;
  localparam int CTRL_ADC_SER = 1;
  localparam int ERR_ADD = 0;
  localparam int ERR_SHL = 1;
  localparam int ERR_MUL = 2;
  localparam int ERR_DIV = 3;
  localparam int ERR_SQRT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/fpm_top.sv ----
// fixed-point math sequencer: code-driven datapath, step counter, adc/dac, axi4-lite status
// Contract
// - operands and results are fixed point, 16 integer and 23 fraction bits.
// - 40-bit sign-magnitude word, bit 39 sign, bits 38..0 magnitude.
// - each circuit acts only on its own code from the stepped code memory.
// - eight internal value registers, spill to external ram when short.
// - add, subtract, negate, shift right/left, absolute value in one clock each.
// - addition overflow saturates magnitude, keeps true sum sign, raises flag.
// - shift left losing a significant magnitude bit raises a flag.
// - multiply forms 78-bit magnitude product rounded to 40-bit result.
// - multiply overflow saturates with sign from operand signs, raises flag.
// - divide keeps 40 bits; overflow or zero divisor saturates and flags.
// - square root of negative gives root of magnitude, positive, and flags.
// - comparator window mask, max, min, and gt/eq/lt/le/ge tests in one cycle.
// - hysteresis compare uses trip state to pick set point b or c.
// - eight trip outputs, steady level by default, pulsed on pulse code.
// - eight single-bit trip registers; any store takes one clock.
// - any result, trip or data, storable into any of eight registers.
// - control eight bipolar adcs, 12/14/16 bit, serial or parallel by control register, adc start code-selected.
// - two dac outputs over 17-bit dac bus or the system data bus.
// - counter steps code address from strapped start, wraps to zero at maximum.
// - errors set flags, sequencing never stops, flag set again on recurrence.
// - step counter restarts after STEP_MAX + 1 steps, 1024 with the default STEP_MAX.
// - code 00000101 enables the divide circuit.
module fpm_top #(
  parameter int ADC_BITS = 16,
  parameter logic [9:0] STEP_MAX = fpm_pkg::STEP_MAX_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [5:0] seg_strap,
  output logic [15:0] code_addr_q,
  input wire logic [7:0] code_in,
  output logic [7:0] adc_start_q,
  input wire logic [15:0] adc_pdata,
  input wire logic adc_sdata,
  output logic [16:0] dac_bus_q,
  output logic [1:0] dac_load_q,
  output logic [7:0] ram_addr_q,
  output logic [39:0] sys_wdata_q,
  output logic ram_we_q,
  output logic [1:0] dac_sys_we_q,
  input wire logic [39:0] sys_rdata,
  output logic [7:0] trip_out_q,
  output logic err_add_q,
  output logic err_shl_q,
  output logic err_mul_q,
  output logic err_div_q,
  output logic err_sqrt_q,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  initial begin
    if (ADC_BITS != 12 && ADC_BITS != 14 && ADC_BITS != 16) begin
      $error("ADC_BITS must be 12, 14 or 16");
    end
  end

  // pin synchronisers
  logic [7:0] code_s1_q, code_q;
  logic [5:0] strap_s1_q, strap_q;
  logic [15:0] adcp_s1_q, adcp_q;
  logic adcs_s1_q, adcs_q;
  logic [39:0] rd_s1_q, rd_q;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      code_s1_q <= 8'h00;
      code_q <= 8'h00;
      strap_s1_q <= 6'h00;
      strap_q <= 6'h00;
      adcp_s1_q <= 16'h0000;
      adcp_q <= 16'h0000;
      adcs_s1_q <= 1'b0;
      adcs_q <= 1'b0;
      rd_s1_q <= 40'h00_0000_0000;
      rd_q <= 40'h00_0000_0000;
    end else begin
      code_s1_q <= code_in;
      code_q <= code_s1_q;
      strap_s1_q <= seg_strap;
      strap_q <= strap_s1_q;
      adcp_s1_q <= adc_pdata;
      adcp_q <= adcp_s1_q;
      adcs_s1_q <= adc_sdata;
      adcs_q <= adcs_s1_q;
      rd_s1_q <= sys_rdata;
      rd_q <= rd_s1_q;
    end
  end

  // state
  logic [39:0] regs_q [fpm_pkg::NREG];
  logic [7:0] tbit_q;
  logic [39:0] res_q;
  logic cmp_q;
  logic [2:0] sel_a_q, sel_b_q, sel_c_q;
  logic [9:0] step_q;
  logic [5:0] seg_q;
  logic [1:0] strap_wait_q;
  logic [15:0] adc_sh_q;
  logic [1:0] ctrl_q;
  logic [4:0] err_q;
  logic [7:0] last_code_q;

  // code decode: one circuit per code
  wire [4:0] grp = code_q[7:3];
  wire [2:0] idx = code_q[2:0];
  wire is_arith = (grp == 5'h00) || (grp == 5'h01) || (code_q == fpm_pkg::C_LE)
                  || (code_q == fpm_pkg::C_GE) || (code_q == fpm_pkg::C_HYST)
                  || (code_q == fpm_pkg::C_WIN);
  wire [39:0] opa = regs_q[sel_a_q];
  wire [39:0] opb = regs_q[sel_b_q];
  wire [39:0] opc = regs_q[sel_c_q];
  wire sa = opa[fpm_pkg::SIGN_BIT];
  wire sb = opb[fpm_pkg::SIGN_BIT];
  wire [38:0] ma = opa[38:0];
  wire [38:0] mb = opb[38:0];
  wire [38:0] mc = opc[38:0];

  // signed views for add and compare
  wire signed [40:0] va = sa ? -$signed({2'b00, ma}) : $signed({2'b00, ma});
  wire signed [40:0] vb = sb ? -$signed({2'b00, mb}) : $signed({2'b00, mb});
  wire signed [40:0] vc = opc[fpm_pkg::SIGN_BIT] ? -$signed({2'b00, mc}) : $signed({2'b00, mc});
  wire sub_op = (code_q == fpm_pkg::C_SUB);
  wire signed [40:0] sum = sub_op ? (va - vb) : (va + vb);
  wire sum_neg = sum[40];
  wire [40:0] sum_abs = sum_neg ? 41'(-sum) : 41'(sum);
  wire add_ovf = sum_abs[40] | sum_abs[39];
  wire [39:0] add_res = add_ovf ? {sum_neg, fpm_pkg::MAG_MAX} : {sum_neg, sum_abs[38:0]};

  // multiply: 78-bit magnitude product, round at fraction boundary
  wire [77:0] prod = ma * mb;
  wire [77:0] prod_r = prod + (78'h1 << (fpm_pkg::FRAC_W - 1));
  wire [54:0] prod_q = prod_r[77:fpm_pkg::FRAC_W];
  wire mul_ovf = |prod_q[54:39];
  wire mul_sign = sa ^ sb;
  wire [39:0] mul_res = mul_ovf ? {mul_sign, fpm_pkg::MAG_MAX} : {mul_sign, prod_q[38:0]};

  // divide: scale dividend by the fraction width, keep 40 bits
  wire [61:0] div_num = {ma, 23'h00_0000};
  wire div_zero = (mb == 39'h00_0000_0000);
  wire [61:0] div_q = div_zero ? 62'h0 : (div_num / {23'h00_0000, mb});
  wire div_err = div_zero | (|div_q[61:39]);
  wire [39:0] div_res = div_err ? {mul_sign, fpm_pkg::MAG_MAX} : {mul_sign, div_q[38:0]};

  // square root on magnitude, result always positive
  function automatic logic [30:0] isqrt(input logic [61:0] v);
    logic [30:0] r;
    logic [30:0] c;
    r = 31'h0;
    for (int i = 30; i >= 0; i--) begin
      c = r | (31'h1 << i);
      if (({31'h0, c} * {31'h0, c}) <= v) begin
        r = c;
      end
    end
    return r;
  endfunction
  wire [30:0] root = isqrt({ma, 23'h00_0000});
  wire [39:0] sqrt_res = {1'b0, 8'h00, root};

  // shifts, negate, absolute
  wire [39:0] shr_res = {sa, 1'b0, ma[38:1]};
  wire [39:0] shl_res = {sa, ma[37:0], 1'b0};
  wire shl_loss = ma[38];

  // comparator
  wire a_gt_b = va > vb;
  wire a_eq_b = va == vb;
  wire signed [40:0] vthr = tbit_q[idx] ? vc : vb;
  wire hyst_trip = va > vthr;
  wire in_win = (va > vb) && (va < vc);
  wire [39:0] cmp_res = in_win ? opa : 40'h00_0000_0000; // window mask

  // arithmetic result and flag selection
  logic [39:0] ar_d;
  logic cmp_d;
  always_comb begin
    ar_d = res_q;
    cmp_d = cmp_q;
    unique case (code_q)
      fpm_pkg::C_ADD, fpm_pkg::C_SUB: ar_d = add_res;
      fpm_pkg::C_NEG: ar_d = {~sa, ma};
      fpm_pkg::C_MUL: ar_d = mul_res;
      fpm_pkg::C_DIV: ar_d = div_res;
      fpm_pkg::C_SQRT: ar_d = sqrt_res;
      fpm_pkg::C_SHR: ar_d = shr_res;
      fpm_pkg::C_SHL: ar_d = shl_res;
      fpm_pkg::C_ABS: ar_d = {1'b0, ma};
      fpm_pkg::C_MAX: ar_d = a_gt_b ? opa : opb;
      fpm_pkg::C_MIN: ar_d = a_gt_b ? opb : opa;
      fpm_pkg::C_WMASK: ar_d = cmp_res;
      fpm_pkg::C_GT: cmp_d = a_gt_b;
      fpm_pkg::C_EQ: cmp_d = a_eq_b;
      fpm_pkg::C_LT: cmp_d = !a_gt_b && !a_eq_b;
      fpm_pkg::C_LE: cmp_d = !a_gt_b;
      fpm_pkg::C_GE: cmp_d = a_gt_b || a_eq_b;
      fpm_pkg::C_HYST: cmp_d = hyst_trip;
      fpm_pkg::C_WIN: cmp_d = in_win;
      default: ar_d = res_q;
    endcase
  end

  // error events this cycle
  wire [4:0] err_ev = {
    (code_q == fpm_pkg::C_SQRT) && sa,
    (code_q == fpm_pkg::C_DIV) && div_err,
    (code_q == fpm_pkg::C_MUL) && mul_ovf,
    (code_q == fpm_pkg::C_SHL) && shl_loss,
    ((code_q == fpm_pkg::C_ADD) || sub_op) && add_ovf
  };

  // adc data: bipolar two's complement, integer part of the word
  wire [15:0] adc_raw = ctrl_q[fpm_pkg::CTRL_ADC_SER] ? adc_sh_q : adcp_q;
  wire signed [15:0] adc_sx = $signed(adc_raw << (16 - ADC_BITS)) >>> (16 - ADC_BITS);
  wire adc_neg = adc_sx[15];
  wire [15:0] adc_mag = adc_neg ? 16'(-adc_sx) : 16'(adc_sx);
  wire [39:0] adc_word = {adc_neg, adc_mag, 23'h00_0000};
  wire [39:0] store_src = (res_q & {40{1'b1}});

  // datapath registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      res_q <= 40'h00_0000_0000;
      cmp_q <= 1'b0;
      sel_a_q <= 3'h0;
      sel_b_q <= 3'h0;
      sel_c_q <= 3'h0;
      tbit_q <= 8'h00;
      last_code_q <= 8'h00;
      for (int i = 0; i < fpm_pkg::NREG; i++) begin
        regs_q[i] <= 40'h00_0000_0000;
      end
    end else begin
      last_code_q <= code_q;
      if (is_arith) begin
        res_q <= ar_d;
        cmp_q <= cmp_d;
      end
      if (grp == fpm_pkg::G_ADCLD) begin
        res_q <= adc_word;
      end
      if (grp == fpm_pkg::G_RAMRD) begin
        res_q <= rd_q;
      end
      if (grp == fpm_pkg::G_SELA) begin
        sel_a_q <= idx;
      end
      if (grp == fpm_pkg::G_SELB) begin
        sel_b_q <= idx;
      end
      if (grp == fpm_pkg::G_SELC) begin
        sel_c_q <= idx;
      end
      if (grp == fpm_pkg::G_STORE) begin
        regs_q[idx] <= store_src;
      end
      if (grp == fpm_pkg::G_TSTORE) begin
        tbit_q[idx] <= cmp_q;
      end
    end
  end

  // step counter and code address
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      step_q <= 10'h000;
      seg_q <= 6'h00;
      strap_wait_q <= 2'h0;
      code_addr_q <= 16'h0000;
    end else begin
      if (strap_wait_q != 2'h3) begin
        strap_wait_q <= strap_wait_q + 2'h1;
        seg_q <= strap_q;
      end
      step_q <= (step_q == STEP_MAX) ? 10'h000 : step_q + 10'h001;
      code_addr_q <= {seg_q, step_q};
    end
  end

  // trip, adc, dac and ram outputs
  logic [7:0] pulse_ev;
  always_comb begin
    pulse_ev = 8'h00;
    if (grp == fpm_pkg::G_PULSE) begin
      pulse_ev[idx] = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trip_out_q <= 8'h00;
      adc_start_q <= 8'h00;
      adc_sh_q <= 16'h0000;
      dac_bus_q <= 17'h0_0000;
      dac_load_q <= 2'h0;
      dac_sys_we_q <= 2'h0;
      ram_addr_q <= 8'h00;
      sys_wdata_q <= 40'h00_0000_0000;
      ram_we_q <= 1'b0;
    end else begin
      trip_out_q <= tbit_q ^ pulse_ev;
      adc_sh_q <= {adc_sh_q[14:0], adcs_q};
      adc_start_q <= 8'h00;
      dac_load_q <= 2'h0;
      dac_sys_we_q <= 2'h0;
      ram_we_q <= 1'b0;
      if (grp == fpm_pkg::G_ADCGO) begin
        adc_start_q[idx] <= 1'b1;
      end
      if (grp == fpm_pkg::G_DAC) begin
        if (ctrl_q[fpm_pkg::CTRL_DAC_SYS]) begin
          sys_wdata_q <= res_q;
          dac_sys_we_q[idx[0]] <= 1'b1;
        end else begin
          dac_bus_q <= {res_q[39], res_q[38:23]};
          dac_load_q[idx[0]] <= 1'b1;
        end
      end
      if (grp == fpm_pkg::G_RAMADR) begin
        ram_addr_q <= {res_q[27:23], idx};
      end
      if (grp == fpm_pkg::G_RAMWR) begin
        sys_wdata_q <= regs_q[idx];
        ram_we_q <= 1'b1;
      end
    end
  end

  // axi4-lite slave decode
  logic aw_got_q, w_got_q;
  logic [7:0] aw_adr_q;
  logic [31:0] w_dat_q;
  logic [3:0] w_stb_q;
  wire do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
  wire wr_ctrl = do_wr && (aw_adr_q == fpm_pkg::A_CTRL) && w_stb_q[0];
  wire wr_stat = do_wr && (aw_adr_q == fpm_pkg::A_STATUS) && w_stb_q[0];
  wire wr_ok = (aw_adr_q == fpm_pkg::A_CTRL) || (aw_adr_q == fpm_pkg::A_STATUS);
  wire [4:0] err_clr = wr_stat ? w_dat_q[4:0] : 5'h00;
  wire [7:0] ar_adr = s_axi_araddr;
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (ar_adr)
      fpm_pkg::A_CTRL: rd_mux = {30'h0, ctrl_q};
      fpm_pkg::A_STATUS: rd_mux = {27'h0, err_q};
      fpm_pkg::A_STEP: rd_mux = {16'h0, seg_q, step_q};
      fpm_pkg::A_RES_LO: rd_mux = res_q[31:0];
      fpm_pkg::A_RES_HI: rd_mux = {24'h0, res_q[39:32]};
      fpm_pkg::A_TRIP: rd_mux = {15'h0, cmp_q, trip_out_q, tbit_q};
      fpm_pkg::A_CODE: rd_mux = {24'h0, last_code_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // error flags: set wins over clear, never stalls sequencing
  wire [4:0] err_d = (err_q & ~err_clr) | err_ev;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      err_q <= 5'h00;
      err_add_q <= 1'b0;
      err_shl_q <= 1'b0;
      err_mul_q <= 1'b0;
      err_div_q <= 1'b0;
      err_sqrt_q <= 1'b0;
      ctrl_q <= 2'h0;
    end else begin
      err_q <= err_d;
      err_add_q <= err_d[fpm_pkg::ERR_ADD];
      err_shl_q <= err_d[fpm_pkg::ERR_SHL];
      err_mul_q <= err_d[fpm_pkg::ERR_MUL];
      err_div_q <= err_d[fpm_pkg::ERR_DIV];
      err_sqrt_q <= err_d[fpm_pkg::ERR_SQRT];
      if (wr_ctrl) begin
        ctrl_q <= w_dat_q[1:0];
      end
    end
  end

  // axi4-lite channel handshakes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_adr_q <= 8'h00;
      w_dat_q <= 32'h0000_0000;
      w_stb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fpm_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fpm_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_adr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_dat_q <= s_axi_wdata;
        w_stb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? fpm_pkg::RESP_OKAY : fpm_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? fpm_pkg::RESP_OKAY : fpm_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ---- tb/fpm_props.sv ----
// checker: timing relations seen at the sequencer ports
module fpm_props #(
  parameter logic [9:0] STEP_MAX = 10'h3FF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] code_addr_q,
  input wire logic [7:0] code_in,
  input wire logic [7:0] adc_start_q,
  input wire logic [1:0] dac_load_q,
  input wire logic err_add_q,
  input wire logic err_shl_q,
  input wire logic err_mul_q,
  input wire logic err_div_q,
  input wire logic err_sqrt_q,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [3:0] cyc_q;
  wire [9:0] stp = code_addr_q[9:0];
  wire [4:0] err_v = {err_sqrt_q, err_div_q, err_mul_q, err_shl_q, err_add_q};
  // cycles since reset release, saturating
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) cyc_q <= 4'h0;
    else if (cyc_q != 4'hF) cyc_q <= cyc_q + 4'h1;
  end
  sequence wr_hs;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_step_wrap: assert property (stp == STEP_MAX |=> stp == 10'h000)
    else $error("step counter did not wrap");
  a_step_count: assert property (cyc_q > 4'h4 && stp != STEP_MAX |=> stp == $past(stp) + 10'h001)
    else $error("step counter did not advance");
  a_seg_steady: assert property (cyc_q > 4'h8 |-> $stable(code_addr_q[15:10]))
    else $error("segment moved");
  a_adc_start: assert property (adc_start_q != 8'h00 |-> $onehot(adc_start_q)
    && ($past(code_in, 3) >> 3) == fpm_pkg::G_ADCGO ##1 adc_start_q == 8'h00)
    else $error("adc start without its code");
  a_dac_load: assert property (dac_load_q != 2'h0 |-> ($past(code_in, 3) >> 3) == fpm_pkg::G_DAC)
    else $error("dac load without its code");
  a_div_code: assert property ($rose(err_div_q) |-> $past(code_in, 3) == fpm_pkg::C_DIV)
    else $error("divide flag without divide code");
  a_sqrt_code: assert property ($rose(err_sqrt_q) |-> $past(code_in, 3) == fpm_pkg::C_SQRT)
    else $error("root flag without root code");
  a_err_sticky: assert property (|($past(err_v) & ~err_v)
    |-> $past(s_axi_awready) || $past(s_axi_awready, 2))
    else $error("error flag dropped without a clear");
  a_wr_resp: assert property (wr_hs |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_rd_resp: assert property (rd_hs |=> s_axi_rvalid)
    else $error("read response late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule

bind fpm_top fpm_props #(.STEP_MAX(STEP_MAX)) i_fpm_props (.*);

// ---- tb/fpm_partner.sv ----
// partner: code memory, adc and scratch ram at the far side
module fpm_partner (
  input wire logic sys_clk,
  input wire logic [15:0] code_addr_q,
  output logic [7:0] code_in,
  input wire logic [15:0] adc_val,
  output logic [15:0] adc_pdata,
  output logic adc_sdata,
  input wire logic [7:0] ram_addr_q,
  input wire logic [39:0] sys_wdata_q,
  input wire logic ram_we_q,
  output logic [39:0] sys_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [65536];
  logic [39:0] ram [256];
  // one code per step from the addressed word
  assign code_in = mem[code_addr_q];
  assign adc_pdata = adc_val;
  assign sys_rdata = ram[ram_addr_q];
  // serial line unused in parallel mode, follows the step parity
  assign adc_sdata = code_addr_q[0];
  // ram write on strobe
  always @(posedge sys_clk) begin
    if (ram_we_q) ram[ram_addr_q] <= sys_wdata_q;
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (ram[i]) ram[i] = 40'h0;
  end
endmodule

// ---- tb/fpm_top_tb.sv ----
// testbench: segment programs run through the sequencer, results read over axi
module fpm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] SM = 10'h03F;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] seg_strap = 6'h00;
  logic [15:0] adc_val = 16'h0000;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, dac_load_q, dac_sys_we_q;
  logic [31:0] s_axi_rdata;
  logic [15:0] code_addr_q, adc_pdata;
  logic [7:0] code_in, adc_start_q, ram_addr_q, trip_out_q;
  logic [16:0] dac_bus_q;
  logic [39:0] sys_wdata_q, sys_rdata;
  logic adc_sdata, ram_we_q, err_add_q, err_shl_q, err_mul_q, err_div_q, err_sqrt_q;
  int num_errors = 0;
  int cmp_count = 0;
  always #25 sys_clk = ~sys_clk;
  fpm_top #(.ADC_BITS(16), .STEP_MAX(SM)) i_fpm_top (.*);
  fpm_partner i_fpm_partner (.*);
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // axi write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1; // late ready, response must hold
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1; // late ready, data must hold
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic load(input logic [5:0] sg, input logic [7:0] q[$]);
    foreach (q[i]) i_fpm_partner.mem[{sg, i[9:0]}] = q[i];
  endtask
  // restart on a segment, let it loop, read the result in the idle stretch
  task automatic run(input logic [5:0] sg, input logic [15:0] v, output logic [39:0] res);
    logic [31:0] lo, hi;
    logic [1:0] r;
    @(posedge sys_clk);
    seg_strap <= sg;
    adc_val <= v;
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3 * (SM + 1)) @(posedge sys_clk);
    while (code_addr_q[9:0] !== 10'h028) begin
      @(posedge sys_clk);
    end
    rd(fpm_pkg::A_STEP, lo, r);
    chk("seg", sg, lo[15:10]);
    rd(fpm_pkg::A_RES_LO, lo, r);
    rd(fpm_pkg::A_RES_HI, hi, r);
    res = {hi[7:0], lo};
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    wr(fpm_pkg::A_CTRL, 32'h0000_0003, r);
    rd(fpm_pkg::A_CTRL, d, r);
    chk("ctrl", 40'h3, d[1:0]);
    wr(fpm_pkg::A_CTRL, 32'h0, r);
    wr(8'h1C, 32'h1, r);
    chk("wr_resp", fpm_pkg::RESP_SLVERR, r);
    rd(8'h1C, d, r);
    chk("rd_resp", {fpm_pkg::RESP_SLVERR, 32'h0}, {r, d});
  endtask
  // zero over zero saturates positive, then goes out on dac 0
  task automatic t_div();
    logic [39:0] v;
    logic [1:0] r;
    load(6'h01, '{8'h48, 8'h50, 8'h05, 8'h80});
    run(6'h01, 16'h0000, v);
    chk("div_res", {1'b0, fpm_pkg::MAG_MAX}, v);
    chk("div_flag", 1'b1, err_div_q);
    chk("dac_bus", 17'h0FFFF, dac_bus_q);
    wr(fpm_pkg::A_CTRL, 32'h0000_0001, r);
    repeat (SM + 1) @(posedge sys_clk);
    chk("dac_sys", {1'b0, fpm_pkg::MAG_MAX}, sys_wdata_q);
  endtask
  // negative adc value squared, compared, kept in trip bit 2
  task automatic t_mul();
    logic [39:0] v;
    load(6'h05, '{8'h68, 8'h40, 8'h48, 8'h50, 8'h04, 8'h41, 8'h49, 8'h0D, 8'h7A});
    run(6'h05, 16'hFFFD, v);
    chk("mul_res", 40'h00_0480_0000, v);
    chk("mul_flag", 1'b0, err_mul_q);
    chk("trip", 8'h04, trip_out_q);
  endtask
  // adc word doubled by add, round trip through external ram
  task automatic t_add();
    logic [39:0] v;
    load(6'h02, '{8'h60, 8'h68, 8'h40, 8'h48, 8'h50, 8'h01, 8'h41, 8'h89,
      8'h68, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90});
    run(6'h02, 16'h0006, v);
    chk("add_res", 40'h00_0600_0000, v);
    chk("no_err", 5'h00, {err_add_q, err_shl_q, err_mul_q, err_div_q, err_sqrt_q});
  endtask
  // root of a negated value: magnitude root, positive, flagged
  task automatic t_sqrt();
    logic [39:0] v;
    load(6'h03, '{8'h68, 8'h40, 8'h48, 8'h03, 8'h41, 8'h49, 8'h06});
    run(6'h03, 16'h0004, v);
    chk("sqrt_res", 40'h00_0100_0000, v);
    chk("sqrt_flag", 1'b1, err_sqrt_q);
  endtask
  // shift loss and add overflow, cleared by software, then set again
  task automatic t_ovf();
    logic [39:0] v;
    logic [31:0] d;
    logic [1:0] r;
    load(6'h04, '{8'h68, 8'h40, 8'h48, 8'h50, 8'h01, 8'h41, 8'h49, 8'h08, 8'h51, 8'h01});
    run(6'h04, 16'h7FFF, v);
    chk("ovf_res", {1'b0, fpm_pkg::MAG_MAX}, v);
    wr(fpm_pkg::A_STATUS, 32'h1F, r);
    repeat (2 * (SM + 1)) @(posedge sys_clk);
    rd(fpm_pkg::A_STATUS, d, r);
    chk("status", 40'h3, d[4:0]);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("rst_out", 40'h0, {trip_out_q, adc_start_q, err_add_q, err_shl_q, err_mul_q, err_div_q,
      err_sqrt_q});
    t_regs();
    t_div();
    t_add();
    t_sqrt();
    t_mul();
    t_ovf();
    end_of_test();
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end
endmodule
